// File: filt_irq_pkg.sv
// Purpose: Shared constants and types for the CAN acceptance filter,
//          interrupt flag and power-mode control block.
// Assumes: APB register bus with 32-bit data, one aligned word per register.
// Notes:   Flag registers are write-one-to-clear; configuration is locked
//          unless the soft-reset bit is set.
package filt_irq_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_CTL_TWO  = 8'h04;
  localparam logic [7:0] OFS_BT_A     = 8'h08;
  localparam logic [7:0] OFS_BT_B     = 8'h0C;
  localparam logic [7:0] OFS_FILT     = 8'h10;
  localparam logic [7:0] OFS_RX_FLAG  = 8'h14;
  localparam logic [7:0] OFS_RX_EN    = 8'h18;
  localparam logic [7:0] OFS_TX_FLAG  = 8'h1C;
  localparam logic [7:0] OFS_TX_EN    = 8'h20;
  localparam logic [7:0] OFS_ERR_CNT  = 8'h24;
  localparam logic [7:0] OFS_PAT0     = 8'h28;
  localparam logic [7:0] OFS_PAT1     = 8'h2C;
  localparam logic [7:0] OFS_MSK0     = 8'h30;
  localparam logic [7:0] OFS_MSK1     = 8'h34;

  // Control register bit positions
  localparam int CTRL_SFT = 0;
  localparam int CTRL_SLP = 1;
  localparam int CTRL_WST = 2;
  // Filter control fields
  localparam int FILT_MODE_LSB = 0;
  localparam int FILT_HIT_LSB  = 4;
  // Receive flag register bit positions
  localparam int RF_RXF  = 0;
  localparam int RF_OVR  = 1;
  localparam int RF_BOFF = 2;
  localparam int RF_TERR = 3;
  localparam int RF_RERR = 4;
  localparam int RF_TWRN = 5;
  localparam int RF_RWRN = 6;
  localparam int RF_WAKE = 7;
  // Error counter read-back fields
  localparam int ERR_TX_LSB = 8;

  // Error counter thresholds
  localparam logic [8:0] WARN_LIMIT    = 9'h060;
  localparam logic [8:0] PASSIVE_LIMIT = 9'h07F;
  localparam logic [8:0] BUSOFF_LIMIT  = 9'h0FF;

  // Reset values and line levels
  localparam logic       SFT_RESET_VAL = 1'h1;
  localparam logic [2:0] TXE_RESET_VAL = 3'h7;
  localparam logic       RECESSIVE     = 1'h1;

  typedef enum logic [1:0] {FM_TWO, FM_FOUR, FM_EIGHT, FM_CLOSED} filt_mode_t;
  typedef enum logic [1:0] {PM_NORMAL, PM_SLEEP, PM_SOFT_RESET, PM_POWER_DOWN} power_mode_t;

  // Received frame header as delivered by the protocol engine
  typedef struct packed {
    logic        ide;
    logic        rtr;
    logic        srr;
    logic [28:0] id;
  } rx_frame_t;

  // Error counters from the protocol engine
  typedef struct packed {
    logic [7:0] rx_err;
    logic [8:0] tx_err;
  } err_count_t;

  // Whole register state of the block
  typedef struct packed {
    logic            soft_reset;
    logic            wait_stop;
    logic [7:0]      ctl_two;
    logic [7:0]      bt_a;
    logic [7:0]      bt_b;
    filt_mode_t      fmode;
    logic [1:0][31:0] pat;
    logic [1:0][31:0] msk;
    logic [7:0]      rx_full_flag;
    logic [7:0]      rx_en;
    logic [2:0]      tx_empty_flag;
    logic [2:0]      tx_en;
    logic [2:0]      hit;
    logic            bg_full;
    logic [2:0]      bg_hit;
    logic            copy;
    logic            tx_out;
    logic            rx_s1;
    logic            rx_s2;
    logic [31:0]     prdata;
  } state_t;

endpackage

// File: can_filter_irq_power_ctrl.sv
// Purpose: CAN receive acceptance filter, interrupt flags and power-mode
//          control with an APB register slave.
// Assumes: Protocol engine on pclk delivers frame_ok at end of frame,
//          transmit-done pulses and error counters; rx_pin is asynchronous.
// Notes:   Zero-wait APB; read data is captured in the setup cycle.
//
// Register access over APB and the register addresses were decided locally.
`timescale 1ns/1ps
module can_filter_irq_power_ctrl (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [7:0]               paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic                     frame_ok,
  input  wire filt_irq_pkg::rx_frame_t  frame,
  input  wire logic [2:0]               tx_done,
  input  wire logic                     core_tx,
  input  wire filt_irq_pkg::err_count_t err_cnt,
  input  wire logic                     sleep_ack,
  input  wire logic                     cpu_stop,
  input  wire logic                     cpu_wait,
  input  wire logic                     rx_pin,
  output logic                          tx_pin,
  output logic                          irq_wakeup,
  output logic                          irq_error,
  output logic                          irq_rx,
  output logic                          irq_tx,
  output logic                          copy_to_fg,
  output logic      [2:0]               filter_hit_index,
  output filt_irq_pkg::power_mode_t     power_mode,
  output logic      [7:0]               control_two,
  output logic      [7:0]               bit_timing_a,
  output logic      [7:0]               bit_timing_b
);

  filt_irq_pkg::state_t      s;
  filt_irq_pkg::state_t      next_s;
  filt_irq_pkg::power_mode_t pm;
  logic [31:0]               fw;
  logic [7:0]                m8;
  logic [3:0]                m16;
  logic [1:0]                m32;
  logic [7:0]                hits;
  logic [2:0]                low_idx;
  logic                      accept;
  logic                      wr;
  logic                      rd_setup;
  logic                      mapped;
  logic [7:0]                err_cond;
  logic [7:0]                rx_set;
  logic [7:0]                rx_clr;

  // Power mode from CPU state and control bits
  always_comb begin
    if (cpu_stop || (cpu_wait && s.wait_stop)) begin
      pm = filt_irq_pkg::PM_POWER_DOWN;
    end else if (sleep_ack && !s.soft_reset) begin
      pm = filt_irq_pkg::PM_SLEEP;
    end else if (s.soft_reset) begin
      pm = filt_irq_pkg::PM_SOFT_RESET;
    end else begin
      pm = filt_irq_pkg::PM_NORMAL;
    end
  end

  // Frame word in bank layout: extended id split around SRR/IDE
  assign fw = frame.ide ? {frame.id[28:18], frame.srr, frame.ide, frame.id[17:0], frame.rtr}
                        : {frame.id[10:0], frame.rtr, frame.ide, 19'h00000};

  // Per-filter compares; a set mask bit is don't care
  for (genvar i = 0; i < 8; i++) begin : g_filt
    // Byte filters: filter i uses bank i/4, first byte at the top
    assign m8[i] = &(~(fw[31:24] ^ s.pat[i/4][31-8*(i%4) -: 8]) | s.msk[i/4][31-8*(i%4) -: 8]);
    if (i < 4) begin : g_half
      // Half-word filters: 11 id bits + RTR, or 14 extended id bits
      assign m16[i] = &(~(fw[31:16] ^ s.pat[i/2][31-16*(i%2) -: 16])
                       | s.msk[i/2][31-16*(i%2) -: 16]);
    end
    if (i < 2) begin : g_full
      // Full-word filters over id, SRR, IDE, RTR
      assign m32[i] = &(~(fw ^ s.pat[i]) | s.msk[i]);
    end
  end

  // Hit vector by mode; closed mode yields none
  always_comb begin
    unique case (s.fmode)
      filt_irq_pkg::FM_TWO:   hits = {6'h00, m32};
      filt_irq_pkg::FM_FOUR:  hits = {4'h0, m16};
      filt_irq_pkg::FM_EIGHT: hits = m8;
      filt_irq_pkg::FM_CLOSED: hits = 8'h00;
    endcase
  end

  // Lowest-numbered hit wins, encoded in binary
  always_comb begin
    low_idx = 3'h0;
    for (int k = 7; k >= 0; k--) begin
      if (hits[k]) begin
        low_idx = 3'(k);
      end
    end
  end

  // Accepted only at end of a good frame in normal or sleep mode
  assign accept = frame_ok && (|hits) && (pm == filt_irq_pkg::PM_NORMAL
                  || pm == filt_irq_pkg::PM_SLEEP);

  // APB decode; registers unreachable in power-down
  assign wr       = psel && penable && pwrite && pm != filt_irq_pkg::PM_POWER_DOWN;
  assign rd_setup = psel && !penable && !pwrite;
  always_comb begin
    unique case (paddr)
      filt_irq_pkg::OFS_CTRL, filt_irq_pkg::OFS_CTL_TWO, filt_irq_pkg::OFS_BT_A,
      filt_irq_pkg::OFS_BT_B, filt_irq_pkg::OFS_FILT, filt_irq_pkg::OFS_RX_FLAG,
      filt_irq_pkg::OFS_RX_EN, filt_irq_pkg::OFS_TX_FLAG, filt_irq_pkg::OFS_TX_EN,
      filt_irq_pkg::OFS_ERR_CNT, filt_irq_pkg::OFS_PAT0, filt_irq_pkg::OFS_PAT1,
      filt_irq_pkg::OFS_MSK0, filt_irq_pkg::OFS_MSK1: mapped = 1'h1;
      default: mapped = 1'h0;
    endcase
  end
  assign pready  = 1'h1;
  assign pslverr = psel && penable && (!mapped || pm == filt_irq_pkg::PM_POWER_DOWN);

  // Error conditions that set and hold flags
  always_comb begin
    err_cond = 8'h00;
    err_cond[filt_irq_pkg::RF_RWRN] = {1'h0, err_cnt.rx_err} >= filt_irq_pkg::WARN_LIMIT;
    err_cond[filt_irq_pkg::RF_TWRN] = err_cnt.tx_err >= filt_irq_pkg::WARN_LIMIT;
    err_cond[filt_irq_pkg::RF_RERR] = {1'h0, err_cnt.rx_err} > filt_irq_pkg::PASSIVE_LIMIT;
    err_cond[filt_irq_pkg::RF_TERR] = err_cnt.tx_err > filt_irq_pkg::PASSIVE_LIMIT;
    err_cond[filt_irq_pkg::RF_BOFF] = err_cnt.tx_err > filt_irq_pkg::BUSOFF_LIMIT;
  end

  // Next-state logic for the whole register set
  always_comb begin
    next_s      = s;
    next_s.copy = 1'h0;
    // Pin synchroniser
    next_s.rx_s1 = rx_pin;
    next_s.rx_s2 = s.rx_s1;
    // Transmit pin forced recessive outside normal mode
    next_s.tx_out = (pm == filt_irq_pkg::PM_NORMAL) ? core_tx : filt_irq_pkg::RECESSIVE;

    // Flag set events
    rx_set = err_cond;
    rx_set[filt_irq_pkg::RF_WAKE] = sleep_ack && !s.rx_s2;
    rx_clr = 8'h00;
    if (wr && paddr == filt_irq_pkg::OFS_RX_FLAG) begin
      rx_clr = pwdata[7:0] & ~err_cond;
    end

    // Software writes; counters have no write path
    if (wr) begin
      unique case (paddr)
        filt_irq_pkg::OFS_CTRL: begin
          next_s.soft_reset = pwdata[filt_irq_pkg::CTRL_SFT];
          next_s.wait_stop  = pwdata[filt_irq_pkg::CTRL_WST];
        end
        filt_irq_pkg::OFS_RX_EN:  next_s.rx_en = pwdata[7:0];
        filt_irq_pkg::OFS_TX_EN:  next_s.tx_en = pwdata[2:0];
        filt_irq_pkg::OFS_TX_FLAG: next_s.tx_empty_flag = s.tx_empty_flag & ~pwdata[2:0];
        default: ;
      endcase
      // Configuration lock
      if (s.soft_reset) begin
        unique case (paddr)
          filt_irq_pkg::OFS_CTL_TWO: next_s.ctl_two = pwdata[7:0];
          filt_irq_pkg::OFS_BT_A:    next_s.bt_a    = pwdata[7:0];
          filt_irq_pkg::OFS_BT_B:    next_s.bt_b    = pwdata[7:0];
          filt_irq_pkg::OFS_FILT:
            next_s.fmode = filt_irq_pkg::filt_mode_t'(pwdata[filt_irq_pkg::FILT_MODE_LSB +: 2]);
          filt_irq_pkg::OFS_PAT0:    next_s.pat[0]  = pwdata;
          filt_irq_pkg::OFS_PAT1:    next_s.pat[1]  = pwdata;
          filt_irq_pkg::OFS_MSK0:    next_s.msk[0]  = pwdata;
          filt_irq_pkg::OFS_MSK1:    next_s.msk[1]  = pwdata;
          default: ;
        endcase
      end
    end
    // Transmit done sets empty flags, winning over a clear
    next_s.tx_empty_flag = next_s.tx_empty_flag | tx_done;

    // In normal mode, release of the foreground buffer pulls the background message forward
    if (rx_clr[filt_irq_pkg::RF_RXF] && s.bg_full && pm == filt_irq_pkg::PM_NORMAL) begin
      rx_set[filt_irq_pkg::RF_RXF] = 1'h1;
      next_s.hit     = s.bg_hit;
      next_s.bg_full = 1'h0;
      next_s.copy    = 1'h1;
    end
    // Accepted frame: foreground, background or overrun
    if (accept) begin
      if (!s.rx_full_flag[filt_irq_pkg::RF_RXF]) begin
        rx_set[filt_irq_pkg::RF_RXF] = 1'h1;
        next_s.hit  = low_idx;
        next_s.copy = 1'h1;
      end else if (!s.bg_full) begin
        next_s.bg_full = 1'h1;
        next_s.bg_hit  = low_idx;
      end else begin
        rx_set[filt_irq_pkg::RF_OVR] = 1'h1;
      end
    end
    // Set wins over clear
    next_s.rx_full_flag = (s.rx_full_flag & ~rx_clr) | rx_set;

    // Read data captured in setup phase
    if (rd_setup) begin
      next_s.prdata = 32'h00000000;
      if (pm != filt_irq_pkg::PM_POWER_DOWN) begin
        unique case (paddr)
          filt_irq_pkg::OFS_CTRL: begin
            next_s.prdata[filt_irq_pkg::CTRL_SFT] = s.soft_reset;
            next_s.prdata[filt_irq_pkg::CTRL_SLP] = sleep_ack;
            next_s.prdata[filt_irq_pkg::CTRL_WST] = s.wait_stop;
          end
          filt_irq_pkg::OFS_CTL_TWO: next_s.prdata[7:0] = s.ctl_two;
          filt_irq_pkg::OFS_BT_A:    next_s.prdata[7:0] = s.bt_a;
          filt_irq_pkg::OFS_BT_B:    next_s.prdata[7:0] = s.bt_b;
          filt_irq_pkg::OFS_FILT: begin
            next_s.prdata[filt_irq_pkg::FILT_MODE_LSB +: 2] = s.fmode;
            next_s.prdata[filt_irq_pkg::FILT_HIT_LSB +: 3]  = s.hit;
          end
          filt_irq_pkg::OFS_RX_FLAG: next_s.prdata[7:0] = s.rx_full_flag;
          filt_irq_pkg::OFS_RX_EN:   next_s.prdata[7:0] = s.rx_en;
          filt_irq_pkg::OFS_TX_FLAG: next_s.prdata[2:0] = s.tx_empty_flag;
          filt_irq_pkg::OFS_TX_EN:   next_s.prdata[2:0] = s.tx_en;
          filt_irq_pkg::OFS_ERR_CNT: begin
            next_s.prdata[7:0] = err_cnt.rx_err;
            next_s.prdata[filt_irq_pkg::ERR_TX_LSB +: 9] = err_cnt.tx_err;
          end
          filt_irq_pkg::OFS_PAT0:    next_s.prdata = s.pat[0];
          filt_irq_pkg::OFS_PAT1:    next_s.prdata = s.pat[1];
          filt_irq_pkg::OFS_MSK0:    next_s.prdata = s.msk[0];
          filt_irq_pkg::OFS_MSK1:    next_s.prdata = s.msk[1];
          default: ;
        endcase
      end
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s            <= '0;
      s.soft_reset <= filt_irq_pkg::SFT_RESET_VAL;
      s.tx_empty_flag        <= filt_irq_pkg::TXE_RESET_VAL;
      s.tx_out     <= filt_irq_pkg::RECESSIVE;
      s.rx_s1      <= filt_irq_pkg::RECESSIVE;
      s.rx_s2      <= filt_irq_pkg::RECESSIVE;
    end else begin
      s <= next_s;
    end
  end

  // Interrupt outputs stay high while any enabled flag is set; the wake-up output also needs sleep_ack
  assign irq_wakeup = s.rx_full_flag[filt_irq_pkg::RF_WAKE] && s.rx_en[filt_irq_pkg::RF_WAKE]
                      && sleep_ack;
  assign irq_error  = |(s.rx_full_flag[filt_irq_pkg::RF_RWRN:filt_irq_pkg::RF_OVR]
                        & s.rx_en[filt_irq_pkg::RF_RWRN:filt_irq_pkg::RF_OVR]);
  assign irq_rx     = s.rx_full_flag[filt_irq_pkg::RF_RXF] && s.rx_en[filt_irq_pkg::RF_RXF];
  assign irq_tx     = |(s.tx_empty_flag & s.tx_en);

  // Data outputs straight from flops, except power_mode which is combinational
  assign prdata           = s.prdata;
  assign tx_pin           = s.tx_out;
  assign copy_to_fg       = s.copy;
  assign filter_hit_index = s.hit;
  assign power_mode       = pm;
  assign control_two      = s.ctl_two;
  assign bit_timing_a     = s.bt_a;
  assign bit_timing_b     = s.bt_b;

  // Checks
  closed_no_rxf_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s.fmode == filt_irq_pkg::FM_CLOSED && !s.rx_full_flag[filt_irq_pkg::RF_RXF] && !s.bg_full)
    |=> !s.rx_full_flag[filt_irq_pkg::RF_RXF])
    else $error("full flag set in closed mode");
  rx_accept_a: assert property (@(posedge pclk) disable iff (!presetn)
    (accept && !s.rx_full_flag[filt_irq_pkg::RF_RXF])
    |=> s.rx_full_flag[filt_irq_pkg::RF_RXF] && filter_hit_index == $past(low_idx))
    else $error("accepted frame not flagged with lowest hit");
  cfg_lock_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && !s.soft_reset) |=> $stable(s.pat) && $stable(s.msk) && $stable(s.fmode)
    && $stable(s.bt_a))
    else $error("locked configuration changed");
  tx_recessive_a: assert property (@(posedge pclk) disable iff (!presetn)
    (pm != filt_irq_pkg::PM_NORMAL) |=> tx_pin == filt_irq_pkg::RECESSIVE)
    else $error("tx pin driven in low-power mode");
  overrun_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    (accept && s.rx_full_flag[filt_irq_pkg::RF_RXF] && s.bg_full) |=> s.rx_full_flag[filt_irq_pkg::RF_OVR]
    && $stable(s.hit))
    else $error("overrun not flagged");
  w1c_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && paddr == filt_irq_pkg::OFS_RX_FLAG && s.rx_full_flag[filt_irq_pkg::RF_OVR]
     && !pwdata[filt_irq_pkg::RF_OVR]) |=> s.rx_full_flag[filt_irq_pkg::RF_OVR])
    else $error("write of zero cleared a flag");
  warn_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    ({1'h0, err_cnt.rx_err} >= filt_irq_pkg::WARN_LIMIT) |=> s.rx_full_flag[filt_irq_pkg::RF_RWRN])
    else $error("warning flag not held");
  busoff_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    (err_cnt.tx_err > filt_irq_pkg::BUSOFF_LIMIT) |=> s.rx_full_flag[filt_irq_pkg::RF_BOFF])
    else $error("bus-off flag not set");
  wake_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    irq_wakeup |-> sleep_ack && s.rx_en[filt_irq_pkg::RF_WAKE])
    else $error("wake interrupt without ack and enable");
  tx_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
    (|(tx_done & s.tx_en) && !(wr && paddr == filt_irq_pkg::OFS_TX_EN)) |=> irq_tx)
    else $error("transmit interrupt missing");
  err_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_setup && paddr == filt_irq_pkg::OFS_ERR_CNT && pm != filt_irq_pkg::PM_POWER_DOWN)
    |=> prdata[7:0] == $past(err_cnt.rx_err))
    else $error("error counter read-back wrong");
  passive_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    ({1'h0, err_cnt.rx_err} > filt_irq_pkg::PASSIVE_LIMIT)
    |=> s.rx_full_flag[filt_irq_pkg::RF_RERR])
    else $error("receive passive flag not set");
  rx_irq_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (irq_rx && !wr)
    |=> irq_rx)
    else $error("receive interrupt dropped while flag set");
  sleep_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!cpu_stop && !cpu_wait && sleep_ack && !s.soft_reset)
    |-> power_mode == filt_irq_pkg::PM_SLEEP)
    else $error("sleep mode not selected");
  two_mode_hit_a: assert property (@(posedge pclk) disable iff (!presetn)
    (accept && !s.rx_full_flag[filt_irq_pkg::RF_RXF] && s.fmode == filt_irq_pkg::FM_TWO)
    |=> filter_hit_index[2:1] == 2'h0)
    else $error("hit index outside two-filter range");
  eight_hit_a: assert property (@(posedge pclk) disable iff (!presetn)
    (accept && !s.rx_full_flag[filt_irq_pkg::RF_RXF] && s.fmode == filt_irq_pkg::FM_EIGHT
     && !(|m8[3:0]) && m8[4])
    |=> filter_hit_index == 3'h4)
    else $error("eight-filter hit index wrong");
  tx_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && paddr == filt_irq_pkg::OFS_TX_FLAG && pwdata[0] && !tx_done[0])
    |=> !s.tx_empty_flag[0])
    else $error("transmit empty flag not cleared");

  cover property (@(posedge pclk) disable iff (!presetn)
    accept && s.fmode == filt_irq_pkg::FM_FOUR);
  cover property (@(posedge pclk) disable iff (!presetn)
    accept && s.rx_full_flag[filt_irq_pkg::RF_RXF] && s.bg_full);
  cover property (@(posedge pclk) disable iff (!presetn) irq_wakeup);
  cover property (@(posedge pclk) disable iff (!presetn) s.copy && !accept);
  cover property (@(posedge pclk) disable iff (!presetn)
    accept && s.fmode == filt_irq_pkg::FM_EIGHT);

endmodule

// File: can_node.sv
// Purpose: Far-side CAN node that can pull the shared bus line dominant.
// Assumes: Wired-AND bus, recessive high, same clock as the bench.
// Notes:   The line goes back to recessive as soon as nobody pulls it low.
`timescale 1ns/1ps
module can_node (
  input  wire logic pclk,
  input  wire logic tx_pin,
  input  wire logic pull,
  output logic      rx_pin
);
  logic held = 1'h0;
  // Move the pull request just after an edge
  always_ff @(posedge pclk) begin
    held <= pull;
  end
  // Wired-AND of our transmitter and the block's transmitter
  assign rx_pin = tx_pin & ~held;
endmodule

// File: can_filter_irq_power_ctrl_test.sv
// Purpose: Self-checking bench for the CAN filter, flag and power-mode block.
// Assumes: Zero-wait APB slave; flags update one edge after their cause.
// Notes:   Expected values come from the small model functions below.
`timescale 1ns/1ps
module can_filter_irq_power_ctrl_test;
  logic                      pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic                      frame_ok, core_tx, sleep_ack, cpu_stop, cpu_wait, rx_pin, tx_pin;
  logic                      pull, copy_to_fg, irq_wakeup, irq_error, irq_rx, irq_tx, cp;
  logic [7:0]                paddr, control_two, bit_timing_a, bit_timing_b;
  logic [31:0]               pwdata, prdata, rd, r, w, k, e;
  logic [2:0]                tx_done, filter_hit_index;
  filt_irq_pkg::rx_frame_t   frame, f;
  filt_irq_pkg::err_count_t  err_cnt;
  filt_irq_pkg::power_mode_t power_mode, x;
  int                        failures, compares, rxv[5], txv[5];

  can_filter_irq_power_ctrl dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .frame_ok, .frame, .tx_done, .core_tx, .err_cnt, .sleep_ack,
    .cpu_stop, .cpu_wait, .rx_pin, .tx_pin, .irq_wakeup, .irq_error, .irq_rx, .irq_tx,
    .copy_to_fg, .filter_hit_index, .power_mode, .control_two, .bit_timing_a, .bit_timing_b);
  can_node node (.pclk, .tx_pin, .pull, .rx_pin);

  // 50 MHz clock
  always #10 pclk = ~pclk;

  // Compare and count
  task automatic chk(string n, logic [31:0] s, logic [31:0] x);
    compares++;
    if (s !== x) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, s);
    end
  endtask

  // One APB transfer, entered just after an edge; idles one cycle after it
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask

  task automatic rdchk(string n, logic [7:0] a, logic [31:0] x);
    apb(1'h0, a, 32'h0);
    chk(n, rd, x);
  endtask

  // One accepted-frame strobe; the copy pulse is sampled mid-cycle while it stands
  task automatic send();
    frame <= f;
    frame_ok <= 1'h1;
    @(posedge pclk);
    frame_ok <= 1'h0;
    @(negedge pclk);
    cp = copy_to_fg;
    @(posedge pclk);
  endtask

  // Model: filter word, error flags and power mode
  function automatic logic [31:0] fw(filt_irq_pkg::rx_frame_t g);
    return g.ide ? {g.id[28:18], g.srr, g.ide, g.id[17:0], g.rtr} : {g.id[10:0], g.rtr, g.ide, 19'h0};
  endfunction
  function automatic logic [31:0] ef(int rx, int tx);
    return {25'h0, rx >= 96, tx >= 96, rx > 127, tx > 127, tx > 255, 2'h0};
  endfunction
  function automatic filt_irq_pkg::power_mode_t pm(logic st, wt, ws, ak, sf);
    if (st | (wt & ws)) return filt_irq_pkg::PM_POWER_DOWN;
    if (ak) return filt_irq_pkg::PM_SLEEP;
    return sf ? filt_irq_pkg::PM_SOFT_RESET : filt_irq_pkg::PM_NORMAL;
  endfunction

  task automatic tally_and_finish();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Watchdog, far beyond the fewer than a thousand cycles the tests need
  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, frame_ok, sleep_ack, cpu_stop, cpu_wait, pull} = '0;
    {paddr, pwdata, frame, f, tx_done, err_cnt} = '0;
    {pclk, failures, compares} = '0;
    core_tx = 1'h1; // Recessive, so the line is idle until the node pulls it
    rxv = '{95, 96, 127, 128, 255};
    txv = '{95, 96, 127, 128, 256};
    void'($urandom(88050));
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    rdchk("ctrl", filt_irq_pkg::OFS_CTRL, 32'h1);
    chk("mode", power_mode, filt_irq_pkg::PM_SOFT_RESET);
    apb(1'h1, filt_irq_pkg::OFS_RX_EN, 32'hFF);
    apb(1'h1, filt_irq_pkg::OFS_CTL_TWO, 32'hA5);
    apb(1'h1, filt_irq_pkg::OFS_BT_A, 32'h3C);
    apb(1'h1, filt_irq_pkg::OFS_BT_B, 32'hC3);
    $display("reset done");
    // Every mode, once with bank 0 hitting under a random mask, once missing
    for (int m = 0; m < 4; m++) begin
      for (int miss = 0; miss < 2; miss++) begin
        {f.ide, f.rtr, f.srr} = 3'($urandom);
        f.id = 29'($urandom);
        r = $urandom;
        w = fw(f);
        k = m == 0 ? w : m == 1 ? {2{w[31:16]}} : {4{w[31:24]}};
        apb(1'h1, filt_irq_pkg::OFS_CTRL, 32'h1);
        apb(1'h1, filt_irq_pkg::OFS_FILT, 32'(m));
        apb(1'h1, filt_irq_pkg::OFS_PAT0, miss ? ~k : k ^ r);
        apb(1'h1, filt_irq_pkg::OFS_MSK0, miss ? 32'h0 : r);
        apb(1'h1, filt_irq_pkg::OFS_PAT1, r);
        apb(1'h1, filt_irq_pkg::OFS_MSK1, 32'hFFFFFFFF);
        apb(1'h1, filt_irq_pkg::OFS_CTRL, 32'h0);
        send();
        chk("copy", cp, 32'(m != 3));
        chk("irq_rx", irq_rx, 32'(m != 3));
        rdchk("rxf", filt_irq_pkg::OFS_RX_FLAG, 32'(m != 3));
        if (m != 3) chk("hit", filter_hit_index, 32'(miss ? 1 << m : 0));
        apb(1'h1, filt_irq_pkg::OFS_RX_FLAG, 32'h1);
        rdchk("rxf_clr", filt_irq_pkg::OFS_RX_FLAG, 32'h0);
      end
    end
    apb(1'h1, filt_irq_pkg::OFS_CTL_TWO, 32'h5A);
    chk("ctl_two", control_two, 32'hA5);
    apb(1'h1, filt_irq_pkg::OFS_BT_A, 32'h00);
    apb(1'h1, filt_irq_pkg::OFS_BT_B, 32'h00);
    chk("bt_a", bit_timing_a, 32'h3C);
    chk("bt_b", bit_timing_b, 32'hC3);
    $display("filters done");
    // Three frames unread: the third is dropped with overrun
    apb(1'h1, filt_irq_pkg::OFS_CTRL, 32'h1);
    apb(1'h1, filt_irq_pkg::OFS_FILT, 32'h0);
    apb(1'h1, filt_irq_pkg::OFS_CTRL, 32'h0);
    repeat (3) send();
    rdchk("ovr", filt_irq_pkg::OFS_RX_FLAG, 32'h3);
    chk("irq_err", irq_error, 32'h1);
    apb(1'h1, filt_irq_pkg::OFS_RX_FLAG, 32'h3);
    rdchk("reload", filt_irq_pkg::OFS_RX_FLAG, 32'h1);
    apb(1'h1, filt_irq_pkg::OFS_RX_FLAG, 32'h1);
    // Transmit empty flags and their interrupt
    apb(1'h1, filt_irq_pkg::OFS_TX_EN, 32'h7);
    chk("irq_tx", irq_tx, 32'h1);
    apb(1'h1, filt_irq_pkg::OFS_TX_FLAG, 32'h7);
    chk("irq_tx0", irq_tx, 32'h0);
    tx_done <= 3'h2;
    @(posedge pclk);
    tx_done <= 3'h0;
    rdchk("txe", filt_irq_pkg::OFS_TX_FLAG, 32'h2);
    $display("flags done");
    // Counter thresholds, clearing while held, counter write refused
    for (int i = 0; i < 5; i++) begin
      err_cnt <= {8'(rxv[i]), 9'(txv[i])};
      repeat (2) @(posedge pclk);
      e = ef(rxv[i], txv[i]);
      apb(1'h1, filt_irq_pkg::OFS_RX_FLAG, 32'h7C);
      rdchk("errf", filt_irq_pkg::OFS_RX_FLAG, e);
      chk("irq_err", irq_error, 32'(e != 0));
      apb(1'h1, filt_irq_pkg::OFS_ERR_CNT, 32'h0);
      rdchk("cnt", filt_irq_pkg::OFS_ERR_CNT, {15'h0, 9'(txv[i]), 8'(rxv[i])});
      err_cnt <= '0;
      @(posedge pclk);
      apb(1'h1, filt_irq_pkg::OFS_RX_FLAG, 32'h7C);
      rdchk("errf0", filt_irq_pkg::OFS_RX_FLAG, 32'h0);
    end
    $display("errors done");
    // Bus activity during sleep
    sleep_ack <= 1'h1;
    pull <= 1'h1;
    repeat (3) @(posedge pclk);
    pull <= 1'h0;
    repeat (3) @(posedge pclk);
    chk("irq_wk", irq_wakeup, 32'h1);
    rdchk("wkf", filt_irq_pkg::OFS_RX_FLAG, 32'h80);
    sleep_ack <= 1'h0;
    repeat (2) @(posedge pclk);
    chk("irq_wk0", irq_wakeup, 32'h0);
    apb(1'h1, filt_irq_pkg::OFS_RX_FLAG, 32'h80);
    $display("wake done");
    // Random power-mode inputs against the model
    core_tx <= 1'h0;
    for (int i = 0; i < 24; i++) begin
      r = $urandom;
      cpu_stop <= 1'h0;
      cpu_wait <= 1'h0;
      sleep_ack <= 1'h0;
      @(posedge pclk);
      apb(1'h1, filt_irq_pkg::OFS_CTRL, {29'h0, r[1], 1'h0, r[0]});
      sleep_ack <= r[2] & ~r[0];
      cpu_wait <= r[3];
      cpu_stop <= r[4] & r[5];
      repeat (2) @(posedge pclk);
      x = pm(r[4] & r[5], r[3], r[1], r[2] & ~r[0], r[0]);
      chk("mode", power_mode, x);
      chk("tx_pin", tx_pin, 32'(x != filt_irq_pkg::PM_NORMAL));
      apb(1'h0, filt_irq_pkg::OFS_CTRL, 32'h0);
      chk("pd_err", err, 32'(x == filt_irq_pkg::PM_POWER_DOWN));
    end
    $display("power done");
    tally_and_finish();
  end
endmodule
